//--- ceg_bit_if.sv
// Bit-level link between the guard top and its recessive-bit counter
interface ceg_bit_if;
  logic bit_tick;
  logic rx_level;
  logic start;
  logic done;
  modport counter (input bit_tick, input rx_level, input start, output done);
  modport ctrl    (output bit_tick, output rx_level, output start, input done);
endinterface : ceg_bit_if

//--- ceg_can_node_model.sv
// Far side model: other bus nodes plus the message RAM arbiter answering requests
module ceg_can_node_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ram_req,
  input  wire logic       ack_on,
  input  wire logic [3:0] ack_dly,
  output logic            can_rx,
  output logic            bit_tick,
  output logic            fdf_slot,
  output logic            res_slot,
  output logic            ram_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // ----------------------------------------------------------------
  // Bus side
  // ----------------------------------------------------------------
  // Bus idles recessive
  initial begin
    can_rx   = 1'b1;
    bit_tick = 1'b0;
    fdf_slot = 1'b0;
    res_slot = 1'b0;
  end
  // Level set well ahead of the sample point to cover the synchroniser
  task automatic send_bit(input logic lvl, input logic fdf, input logic res);
    @(posedge pclk);
    can_rx <= lvl;
    repeat (3) @(posedge pclk);
    bit_tick <= 1'b1;
    fdf_slot <= fdf;
    res_slot <= res;
    @(posedge pclk);
    bit_tick <= 1'b0;
    fdf_slot <= 1'b0;
    res_slot <= 1'b0;
  endtask : send_bit
  // ----------------------------------------------------------------
  // RAM arbiter
  // ----------------------------------------------------------------
  // Silent when ack_on is low, so the guard must time out
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q   <= 4'h0;
      ram_ack <= 1'b0;
    end else begin
      ram_ack <= 1'b0;
      if (ram_req && ack_on) begin
        cnt_q <= ack_dly;
      end else if (cnt_q != 4'h0) begin
        cnt_q   <= cnt_q - 4'h1;
        ram_ack <= (cnt_q == 4'h1);
      end
    end
  end
endmodule : ceg_can_node_model

//--- ceg_guard.sv
// CAN exception handling, bus integration and message RAM guard top
// What this block does
// [RL1] With exception handling on, a recessive FDF then recessive res bit flags an event and enters integration.
// [RL2] Integration ends after 11 consecutive recessive bits.
// [RL3] Setting the exception-disable bit to 1 stops the res bit from forcing integration.
// [RL4] A RAM timeout during storage leaves the frame incomplete, discards it on the next reception and sets the access-fail flag.
// [RL5] An enabled access-fail flag raises the host interrupt line.
// [RL6] Software programs the watchdog timeout to the longest expected RAM access delay.
// [RL7] No RAM answer within the watchdog time sets the watchdog flag.
// [RL8] Software discards the frame received after the access-fail flag rose once the watchdog flag is set.
// [RL9] Software clears a spurious access-fail flag when error passive and the receive count is 127.
// [RL10] Fail and watchdog flags stay set until cleared; all flags and counters reset to zero.
module ceg_guard
  import ceg_pkg::*;
#(
  parameter int WDOG_W = 16
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire logic                     can_rx,
  input  wire logic                     bit_tick,
  input  wire logic                     fdf_slot,
  input  wire logic                     res_slot,
  input  wire logic                     rx_store_start,
  input  wire logic                     ram_req,
  input  wire logic                     ram_ack,
  input  wire logic [CEG_ERR_CNT_W-1:0] rx_error_count,
  input  wire logic                     rx_error_passive,
  output logic                          bus_integrating,
  output logic                          store_abort,
  output logic                          frame_discard,
  output logic                          irq
);
  // ----------------------------------------------------------------
  // Pin synchroniser
  // ----------------------------------------------------------------
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= can_rx;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic                 proto_exception_disable;
  logic [CEG_IRQ_W-1:0] sts_q, sts_d, mask_q, sts_set;
  logic [WDOG_W-1:0]    wdog_q;
  logic                 pready_q;
  ceg_state_t           state_q;

  wire access  = psel && penable;
  wire wr_en   = access && pready_q && pwrite;
  wire hit_ctl = (paddr == CEG_OFS_CTRL);
  wire hit_irq = (paddr == CEG_OFS_IRQ);
  wire hit_msk = (paddr == CEG_OFS_MASK);
  wire hit_wdg = (paddr == CEG_OFS_WDOG);
  wire hit_err = (paddr == CEG_OFS_ERRCNT);
  wire mapped  = hit_ctl || hit_irq || hit_msk || hit_wdg || hit_err;
  wire [CEG_IRQ_W-1:0] sts_clr = (wr_en && hit_irq) ? pwdata[CEG_IRQ_W-1:0] : '0;

  wire [31:0] rd_ctl = {23'h00_0000, (state_q == CEG_INTEGRATE), 7'h00,
                        proto_exception_disable};
  wire [31:0] rd_err = {16'h0000, rx_error_passive, 8'h00, rx_error_count};
  wire [31:0] rd_mux = hit_ctl ? rd_ctl :
                       hit_irq ? {29'h0000_0000, sts_q} :
                       hit_msk ? {29'h0000_0000, mask_q} :
                       hit_wdg ? {{(32-WDOG_W){1'b0}}, wdog_q} :
                       hit_err ? rd_err : 32'h0000_0000;

  // One wait state: data and answer are both registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata   <= 32'h0000_0000;
      pslverr  <= 1'b0;
    end else begin
      pready_q <= access && !pready_q;
      prdata   <= (access && !pready_q && !pwrite) ? rd_mux : prdata;
      pslverr  <= access && !pready_q && !mapped;
    end
  end
  assign pready = pready_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      proto_exception_disable <= 1'b0;
      mask_q                  <= CEG_IRQ_RST;
      wdog_q                  <= WDOG_W'(CEG_WDOG_RST);
    end else if (wr_en) begin
      if (hit_ctl) proto_exception_disable <= pwdata[CEG_CTRL_PXD];
      if (hit_msk) mask_q <= pwdata[CEG_IRQ_W-1:0];
      if (hit_wdg) wdog_q <= pwdata[WDOG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Protocol exception and bus integration
  // ----------------------------------------------------------------
  ceg_bit_if bif ();
  logic fdf_rec_q;
  wire  exc_event = bit_tick && res_slot && rx_s2_q && fdf_rec_q
                    && !proto_exception_disable && (state_q == CEG_RECEIVE); // RL1 RL3

  assign bif.bit_tick = bit_tick;
  assign bif.rx_level = rx_s2_q;
  assign bif.start    = exc_event;

  ceg_recessive_counter #(.N(CEG_INTEG_BITS)) u_cnt (
    .pclk    (pclk),
    .presetn (presetn),
    .b       (bif)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fdf_rec_q <= 1'b0;
      state_q   <= CEG_INTEGRATE;
    end else begin
      if (bit_tick) fdf_rec_q <= fdf_slot && rx_s2_q;
      unique case (state_q)
        CEG_RECEIVE:   if (exc_event) state_q <= CEG_INTEGRATE; // RL1
        CEG_INTEGRATE: if (bif.done)  state_q <= CEG_RECEIVE;   // RL2
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Message RAM watchdog
  // ----------------------------------------------------------------
  logic              ram_wait_q, incomplete_q;
  logic [WDOG_W-1:0] wcnt_q;
  // Zero timeout leaves the watchdog off rather than firing at once
  wire wd_event = ram_wait_q && !ram_ack && (wdog_q != '0) && (wcnt_q == wdog_q); // RL7

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_wait_q   <= 1'b0;
      wcnt_q       <= '0;
      incomplete_q <= 1'b0;
    end else begin
      ram_wait_q <= (ram_req || ram_wait_q) && !ram_ack && !wd_event;
      wcnt_q     <= (ram_wait_q && !ram_ack && !wd_event) ? wcnt_q + 1'b1 : '0;
      if (wd_event)            incomplete_q <= 1'b1; // RL4
      else if (rx_store_start) incomplete_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags, set wins over clear
  // ----------------------------------------------------------------
  always_comb begin
    sts_set               = '0;
    sts_set[CEG_IRQ_PEV]  = exc_event;
    sts_set[CEG_IRQ_FAIL] = wd_event; // RL4
    sts_set[CEG_IRQ_WDOG] = wd_event; // RL7
    sts_d                 = (sts_q & ~sts_clr) | sts_set; // RL10
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sts_q           <= CEG_IRQ_RST;
      irq             <= 1'b0;
      bus_integrating <= 1'b1;
      store_abort     <= 1'b0;
      frame_discard   <= 1'b0;
    end else begin
      sts_q           <= sts_d;
      irq             <= |(sts_q & mask_q); // RL5
      bus_integrating <= (state_q == CEG_INTEGRATE);
      store_abort     <= wd_event;
      frame_discard   <= rx_store_start && incomplete_q; // RL4
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [3:0] run_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) run_q <= 4'h0;
    else if (exc_event) run_q <= 4'h0;
    else if (bit_tick) run_q <= rx_s2_q ? ((run_q == 4'hF) ? run_q : run_q + 1'b1) : 4'h0;
  end

  // Only covers back-to-back bits four idle cycles apart
  sequence s_fdf_res;
    (bit_tick && fdf_slot && rx_s2_q) ##1 (!bit_tick)[*4] ##1 (bit_tick && res_slot && rx_s2_q);
  endsequence
  property p_exc_enter;
    (state_q == CEG_RECEIVE && !proto_exception_disable && fdf_rec_q
     && bit_tick && res_slot && rx_s2_q) |=> state_q == CEG_INTEGRATE ##1 bus_integrating;
  endproperty
  a_exc_enter: assert property (p_exc_enter) else $error("No integration after exception"); // RL1
  property p_exc_flag;
    ((state_q == CEG_RECEIVE && !proto_exception_disable) ##0 s_fdf_res)
      |=> sts_q[CEG_IRQ_PEV];
  endproperty
  a_exc_flag: assert property (p_exc_flag) else $error("Exception event not flagged"); // RL1
  property p_leave_count;
    $fell(bus_integrating) |-> $past(run_q, 2) == 4'(CEG_INTEG_BITS);
  endproperty
  a_leave_count: assert property (p_leave_count) else $error("Left integration early"); // RL2
  property p_disable;
    (state_q == CEG_RECEIVE && proto_exception_disable) |=> state_q == CEG_RECEIVE;
  endproperty
  a_disable: assert property (p_disable) else $error("Integration despite disable"); // RL3
  property p_wd_flags;
    $rose(store_abort) |-> sts_q[CEG_IRQ_FAIL] && sts_q[CEG_IRQ_WDOG];
  endproperty
  a_wd_flags: assert property (p_wd_flags) else $error("Timeout flags missing"); // RL4
  property p_discard;
    (incomplete_q && rx_store_start) |=> frame_discard ##1 !incomplete_q;
  endproperty
  a_discard: assert property (p_discard) else $error("Incomplete frame not discarded"); // RL4
  property p_irq;
    (sts_q[CEG_IRQ_FAIL] && mask_q[CEG_IRQ_FAIL]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("Fail flag gave no interrupt"); // RL5
  property p_wd_time;
    ($rose(ram_wait_q) && wdog_q == 16'h0003 && !ram_ack) ##1 (!ram_ack && $stable(wdog_q))[*3]
      |=> sts_q[CEG_IRQ_WDOG];
  endproperty
  a_wd_time: assert property (p_wd_time) else $error("Watchdog flag late"); // RL7
  property p_sticky;
    (sts_q[CEG_IRQ_FAIL] && !(wr_en && hit_irq && pwdata[CEG_IRQ_FAIL])) |=> sts_q[CEG_IRQ_FAIL];
  endproperty
  a_sticky: assert property (p_sticky) else $error("Fail flag lost"); // RL10
endmodule : ceg_guard

//--- ceg_guard_tb.sv
// Self-checking bench for the CAN exception and message RAM guard
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t got %h expected %h", $time, (g), (e)); end end
module ceg_guard_tb
  import ceg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic                     pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic                     rx_store_start = 0, ram_req = 0, rx_error_passive = 0, ack_on = 0;
  logic [7:0]               paddr = 8'h00;
  logic [31:0]              pwdata = 32'h0000_0000, prdata, rd;
  logic [CEG_ERR_CNT_W-1:0] rx_error_count = 7'h00;
  logic                     pready, pslverr, can_rx, bit_tick, fdf_slot, res_slot, ram_ack;
  logic                     bus_integrating, store_abort, frame_discard, irq;
  int                       num_errors = 0, n_compared = 0, cyc = 0, n;
  always #10 pclk = ~pclk;
  ceg_guard #(.WDOG_W(16)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .can_rx(can_rx), .bit_tick(bit_tick),
    .fdf_slot(fdf_slot), .res_slot(res_slot), .rx_store_start(rx_store_start),
    .ram_req(ram_req), .ram_ack(ram_ack), .rx_error_count(rx_error_count),
    .rx_error_passive(rx_error_passive), .bus_integrating(bus_integrating),
    .store_abort(store_abort), .frame_discard(frame_discard), .irq(irq));
  ceg_can_node_model node (.pclk(pclk), .presetn(presetn), .ram_req(ram_req),
    .ack_on(ack_on), .ack_dly(4'h1), .can_rx(can_rx), .bit_tick(bit_tick),
    .fdf_slot(fdf_slot), .res_slot(res_slot), .ram_ack(ram_ack));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    `CHK(pslverr, err)
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, 1'b0);
    `CHK(rd, e)
  endtask : chk_rd
  task automatic bits(input int k, input logic lvl);
    repeat (k) node.send_bit(lvl, 1'b0, 1'b0);
    repeat (3) @(posedge pclk);
  endtask : bits
  task automatic ram_op();
    @(posedge pclk);
    rx_store_start <= 1'b1;
    @(posedge pclk);
    rx_store_start <= 1'b0;
    ram_req        <= 1'b1;
    @(posedge pclk);
    ram_req        <= 1'b0;
  endtask : ram_op
  // Hang guard, well above the few hundred cycles the sequence needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    `CHK(bus_integrating, 1'b1)
    presetn <= 1'b1;
    chk_rd(CEG_OFS_IRQ, 32'h0000_0000);
    chk_rd(CEG_OFS_WDOG, 32'h0000_0000);
    chk_rd(CEG_OFS_CTRL, 32'h0000_0100);
    apb(1'b0, 8'h14, 32'h0000_0000, 1'b1);
    `CHK(rd, 32'h0000_0000)
    // A dominant bit restarts the idle count
    bits(5, 1'b1);
    bits(1, 1'b0);
    bits(10, 1'b1);
    `CHK(bus_integrating, 1'b1)
    bits(1, 1'b1);
    `CHK(bus_integrating, 1'b0)
    apb(1'b1, CEG_OFS_MASK, 32'h0000_0001, 1'b0);
    node.send_bit(1'b1, 1'b1, 1'b0);
    node.send_bit(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    `CHK(bus_integrating, 1'b1)
    `CHK(irq, 1'b1)
    chk_rd(CEG_OFS_IRQ, 32'h0000_0001);
    apb(1'b1, CEG_OFS_IRQ, 32'h0000_0001, 1'b0);
    chk_rd(CEG_OFS_IRQ, 32'h0000_0000);
    `CHK(irq, 1'b0)
    bits(11, 1'b1);
    `CHK(bus_integrating, 1'b0)
    apb(1'b1, CEG_OFS_CTRL, 32'h0000_0001, 1'b0);
    node.send_bit(1'b1, 1'b1, 1'b0);
    node.send_bit(1'b1, 1'b0, 1'b1);
    repeat (3) @(posedge pclk);
    `CHK(bus_integrating, 1'b0)
    chk_rd(CEG_OFS_IRQ, 32'h0000_0000);
    chk_rd(CEG_OFS_CTRL, 32'h0000_0001);
    // Watchdog timeout of 3 with the RAM silent
    apb(1'b1, CEG_OFS_MASK, 32'h0000_0002, 1'b0);
    apb(1'b1, CEG_OFS_WDOG, 32'h0000_0003, 1'b0);
    rx_error_count   <= 7'h7F;
    rx_error_passive <= 1'b1;
    ram_op();
    n = 0;
    do begin @(posedge pclk); n++; end while (store_abort !== 1'b1 && n < 12);
    `CHK(n, 5)
    @(posedge pclk);
    `CHK(irq, 1'b1)
    chk_rd(CEG_OFS_IRQ, 32'h0000_0006);
    chk_rd(CEG_OFS_ERRCNT, 32'h0000_807F);
    @(posedge pclk);
    rx_store_start <= 1'b1;
    @(posedge pclk);
    rx_store_start <= 1'b0;
    n = 0;
    do begin @(posedge pclk); n++; end while (frame_discard !== 1'b1 && n < 4);
    `CHK(frame_discard, 1'b1)
    repeat (20) @(posedge pclk);
    chk_rd(CEG_OFS_IRQ, 32'h0000_0006);
    apb(1'b1, CEG_OFS_IRQ, 32'h0000_0002, 1'b0);
    chk_rd(CEG_OFS_IRQ, 32'h0000_0004);
    `CHK(irq, 1'b0)
    apb(1'b1, CEG_OFS_IRQ, 32'h0000_0004, 1'b0);
    // Prompt RAM answer must not trip the watchdog
    ack_on <= 1'b1;
    ram_op();
    repeat (10) @(posedge pclk);
    chk_rd(CEG_OFS_IRQ, 32'h0000_0000);
    report_and_stop();
  end
endmodule : ceg_guard_tb

//--- ceg_pkg.sv
// Shared constants for the CAN exception and message RAM guard block
package ceg_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CEG_OFS_CTRL   = 8'h00;
  localparam logic [7:0] CEG_OFS_IRQ    = 8'h04;
  localparam logic [7:0] CEG_OFS_MASK   = 8'h08;
  localparam logic [7:0] CEG_OFS_WDOG   = 8'h0C;
  localparam logic [7:0] CEG_OFS_ERRCNT = 8'h10;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CEG_CTRL_PXD   = 0;
  localparam int CEG_CTRL_INTEG = 8;
  localparam int CEG_IRQ_PEV    = 0;
  localparam int CEG_IRQ_FAIL   = 1;
  localparam int CEG_IRQ_WDOG   = 2;
  localparam int CEG_IRQ_W      = 3;
  localparam int CEG_ERR_CNT_W  = 7;
  localparam int CEG_ERR_PSV    = 15;
  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [CEG_IRQ_W-1:0] CEG_IRQ_RST  = 3'h0;
  localparam logic [15:0]          CEG_WDOG_RST = 16'h0000;
  localparam int                   CEG_INTEG_BITS = 11;
  typedef enum logic [0:0] {CEG_RECEIVE, CEG_INTEGRATE} ceg_state_t;
endpackage : ceg_pkg

//--- ceg_recessive_counter.sv
// Counter of consecutive recessive bits for bus integration
module ceg_recessive_counter #(
  parameter int N = 11
) (
  input  wire logic   pclk,
  input  wire logic   presetn,
  ceg_bit_if.counter  b
);
  localparam int CW = $clog2(N + 1);
  localparam logic [CW-1:0] LAST = CW'(N - 1);

  logic [CW-1:0] cnt_q;

  // Dominant bit restarts the run; no prior dominant bit is required
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= '0;
      b.done <= 1'b0;
    end else if (b.start) begin
      cnt_q  <= '0;
      b.done <= 1'b0;
    end else begin
      b.done <= b.bit_tick && b.rx_level && (cnt_q == LAST);
      if (b.bit_tick) begin
        cnt_q <= (b.rx_level && cnt_q != LAST) ? cnt_q + 1'b1 : '0;
      end
    end
  end
endmodule : ceg_recessive_counter
